/* File: include/tlic_map.svh */
// Register offsets, field positions, reset values and timing counts of the controller
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TLIC_OFF_CTRL_MAIN   4'h0
`define TLIC_OFF_RESET_CTRL  4'h1
`define TLIC_OFF_EDGE_PRIO   4'h2
`define TLIC_OFF_PERI_FLAG   4'h3
`define TLIC_OFF_PERI_EN     4'h4
`define TLIC_OFF_PERI_PRIO   4'h5
`define TLIC_OFF_STATUS      4'h6

// ----------------------------------------------------------------
// Field positions in the main control register
// ----------------------------------------------------------------
`define TLIC_B_GEN_HI    7
`define TLIC_B_GEN_LO    6
`define TLIC_B_T0_EN     5
`define TLIC_B_X0_EN     4
`define TLIC_B_PC_EN     3
`define TLIC_B_T0_FLAG   2
`define TLIC_B_X0_FLAG   1
`define TLIC_B_PC_FLAG   0

// Field positions elsewhere
`define TLIC_B_PRIO_ON   7
`define TLIC_B_X0_EDGE   6
`define TLIC_B_T0_PRIO   2
`define TLIC_B_PC_PRIO   0

// ----------------------------------------------------------------
// Reset values, vectors, latency
// ----------------------------------------------------------------
`define TLIC_RST_CTRL_MAIN  8'h00
`define TLIC_RST_RESET_CTRL 8'h00
`define TLIC_RST_EDGE_PRIO  8'h45
`define TLIC_RST_PERI       8'h00
`define TLIC_RST_PERI_PRIO  8'hFF
`define TLIC_VEC_HIGH       21'h000008
`define TLIC_VEC_LOW        21'h000018
`define TLIC_INSTR_CLKS     2'h3
`define TLIC_LAT_INSTR      2'h3

`endif

/* File: include/tlic_pkg.sv */
// Types shared by the two-level interrupt controller
package tlic_pkg;
  typedef logic [7:0]  tlic_byte_t;
  typedef logic [20:0] tlic_addr_t;
  typedef enum logic [1:0] {TLIC_RUN, TLIC_IN_LOW, TLIC_IN_HIGH} tlic_level_e;
endpackage : tlic_pkg

/* File: core/tlic_core.sv */
// Two-level interrupt controller with register port and core vector handshake
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "tlic_map.svh"

module tlic_core #(
  parameter int NUM_PERI = 8
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire tlic_pkg::tlic_byte_t  reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output tlic_pkg::tlic_byte_t       reg_rdata,
  // Event sources
  input  wire logic                  ext_pin0,
  input  wire logic [3:0]            upper_portb_pins,
  input  wire logic                  timer0_overflow,
  input  wire logic [NUM_PERI-1:0]   peri_event,
  // Processor core side
  input  wire tlic_pkg::tlic_addr_t  core_pc,
  input  wire logic                  return_from_irq_instr,
  output logic                       irq_take,
  output tlic_pkg::tlic_addr_t       irq_vector,
  output logic                       stack_push,
  output tlic_pkg::tlic_addr_t       stack_push_addr,
  output tlic_pkg::tlic_byte_t       active_level
);
  import tlic_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q, sync2_q, prev_q;
  logic [4:0] sync1_d, sync2_d, prev_d;

  always_comb begin
    sync1_d = {ext_pin0, upper_portb_pins};
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q  <= 5'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tlic_byte_t ctrl_q, ctrl_d;
  tlic_byte_t reset_control_reg_q, reset_control_reg_d;
  tlic_byte_t edge_prio_q, edge_prio_d;
  logic [NUM_PERI-1:0] pflag_q, pflag_d, pen_q, pen_d, pprio_q, pprio_d;
  tlic_byte_t rdata_q, rdata_d;
  tlic_level_e level_q, level_d;
  logic low_nested_q, low_nested_d;
  logic [1:0] cyc_q, cyc_d;
  logic [1:0] wait_q, wait_d;
  logic pend_q, pend_d;
  logic pend_high_q, pend_high_d;
  logic take_q, take_d;
  tlic_addr_t vec_q, vec_d, ret_q, ret_d;

  logic ev_x0, ev_pc, want_hi, want_lo, hi_src, lo_src, restore_hi;
  logic [NUM_PERI-1:0] peri_req;

  function automatic logic wr_hit(input logic [3:0] off);
    return reg_wr && (reg_addr == off);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Event detection and request sorting
  // ----------------------------------------------------------------
  always_comb begin
    // Edge polarity chosen for ext_pin0 only, rising when select is 1; port pins flag any change
    ev_x0 = edge_prio_q[`TLIC_B_X0_EDGE] ? (sync2_q[4] & ~prev_q[4])
                                         : (~sync2_q[4] & prev_q[4]);
    ev_pc = |(sync2_q[3:0] ^ prev_q[3:0]);
    peri_req = pflag_q & pen_q;
    hi_src = 1'b0;
    lo_src = 1'b0;
    if (reset_control_reg_q[`TLIC_B_PRIO_ON]) begin
      hi_src = (ctrl_q[`TLIC_B_T0_FLAG] & ctrl_q[`TLIC_B_T0_EN] & edge_prio_q[`TLIC_B_T0_PRIO])
             | (ctrl_q[`TLIC_B_PC_FLAG] & ctrl_q[`TLIC_B_PC_EN] & edge_prio_q[`TLIC_B_PC_PRIO])
             | (ctrl_q[`TLIC_B_X0_FLAG] & ctrl_q[`TLIC_B_X0_EN])
             | |(peri_req & pprio_q);
      lo_src = (ctrl_q[`TLIC_B_T0_FLAG] & ctrl_q[`TLIC_B_T0_EN] & ~edge_prio_q[`TLIC_B_T0_PRIO])
             | (ctrl_q[`TLIC_B_PC_FLAG] & ctrl_q[`TLIC_B_PC_EN] & ~edge_prio_q[`TLIC_B_PC_PRIO])
             | |(peri_req & ~pprio_q);
      want_hi = hi_src & ctrl_q[`TLIC_B_GEN_HI];
      // Low never preempts high; high preempts low
      want_lo = lo_src & ctrl_q[`TLIC_B_GEN_LO] & (level_q == TLIC_RUN);
    end else begin
      // Priority bits ignored, peripherals need bit 6
      hi_src = (ctrl_q[`TLIC_B_T0_FLAG] & ctrl_q[`TLIC_B_T0_EN])
             | (ctrl_q[`TLIC_B_PC_FLAG] & ctrl_q[`TLIC_B_PC_EN])
             | (ctrl_q[`TLIC_B_X0_FLAG] & ctrl_q[`TLIC_B_X0_EN])
             | (|peri_req & ctrl_q[`TLIC_B_GEN_LO]);
      want_hi = hi_src & ctrl_q[`TLIC_B_GEN_HI];
      want_lo = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file, flags and global enables
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d      = ctrl_q;
    reset_control_reg_d      = reset_control_reg_q;
    edge_prio_d = edge_prio_q;
    pflag_d     = pflag_q;
    pen_d       = pen_q;
    pprio_d     = pprio_q;

    if (wr_hit(`TLIC_OFF_CTRL_MAIN)) ctrl_d = reg_wdata;
    if (wr_hit(`TLIC_OFF_RESET_CTRL)) reset_control_reg_d = reg_wdata;
    if (wr_hit(`TLIC_OFF_EDGE_PRIO)) edge_prio_d = reg_wdata;
    if (wr_hit(`TLIC_OFF_PERI_FLAG)) pflag_d = reg_wdata[NUM_PERI-1:0];
    if (wr_hit(`TLIC_OFF_PERI_EN)) pen_d = reg_wdata[NUM_PERI-1:0];
    if (wr_hit(`TLIC_OFF_PERI_PRIO)) pprio_d = reg_wdata[NUM_PERI-1:0];

    // Events set after any software write so the set wins
    if (ev_pc) ctrl_d[`TLIC_B_PC_FLAG] = 1'b1;
    if (ev_x0) ctrl_d[`TLIC_B_X0_FLAG] = 1'b1;
    if (timer0_overflow) ctrl_d[`TLIC_B_T0_FLAG] = 1'b1;
    pflag_d = pflag_d | peri_event;

    // Return restores the enable cleared on entry
    if (return_from_irq_instr) begin
      if (restore_hi) begin
        ctrl_d[`TLIC_B_GEN_HI] = 1'b1;
      end else begin
        ctrl_d[`TLIC_B_GEN_LO] = 1'b1;
      end
    end

    // Acceptance clears the enable that admitted it
    if (take_d) begin
      if (pend_high_q) begin
        ctrl_d[`TLIC_B_GEN_HI] = 1'b0;
      end else begin
        ctrl_d[`TLIC_B_GEN_LO] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q       <= `TLIC_RST_CTRL_MAIN;
      reset_control_reg_q       <= `TLIC_RST_RESET_CTRL;
      edge_prio_q  <= `TLIC_RST_EDGE_PRIO;
      pflag_q      <= '0;
      pen_q        <= '0;
      pprio_q      <= '1;
    end else begin
      ctrl_q       <= ctrl_d;
      reset_control_reg_q       <= reset_control_reg_d;
      edge_prio_q  <= edge_prio_d;
      pflag_q      <= pflag_d;
      pen_q        <= pen_d;
      pprio_q      <= pprio_d;
    end
  end

  // ----------------------------------------------------------------
  // Routine level and vectoring
  // ----------------------------------------------------------------
  // Compatibility mode and high routines both give back the top enable
  assign restore_hi = !reset_control_reg_q[`TLIC_B_PRIO_ON] || (level_q == TLIC_IN_HIGH);

  always_comb begin
    level_d      = level_q;
    low_nested_d = low_nested_q;
    pend_d       = pend_q;
    pend_high_d  = pend_high_q;
    wait_d       = wait_q;
    take_d       = 1'b0;
    vec_d        = vec_q;
    ret_d        = ret_q;
    // Instruction cycle counter, one instruction is TLIC_INSTR_CLKS clocks
    cyc_d = (cyc_q == `TLIC_INSTR_CLKS - 2'h1) ? 2'h0 : cyc_q + 2'h1;

    // Return leaves the routine; a nested high goes back to low
    if (return_from_irq_instr) begin
      if (restore_hi) begin
        level_d = low_nested_q ? TLIC_IN_LOW : TLIC_RUN;
        low_nested_d = 1'b0;
      end else begin
        level_d = TLIC_RUN;
      end
    end

    // Request seen: vector on whole instruction boundaries
    // A request caught on a boundary counts it, so a pin event never
    // waits past four instruction cycles despite the synchroniser
    if (!pend_q && (want_hi || want_lo)) begin
      pend_d = 1'b1;
      pend_high_d = want_hi;
      wait_d = (cyc_q == 2'h0) ? `TLIC_LAT_INSTR - 2'h1 : `TLIC_LAT_INSTR;
    end else if (pend_q && cyc_q == 2'h0) begin
      if (wait_q != 2'h1) begin
        wait_d = wait_q - 2'h1;
      end else begin
        pend_d = 1'b0;
        take_d = 1'b1;
        ret_d = core_pc;
        if (pend_high_q) begin
          vec_d = `TLIC_VEC_HIGH;
          low_nested_d = (level_q == TLIC_IN_LOW);
          level_d = TLIC_IN_HIGH;
        end else begin
          vec_d = `TLIC_VEC_LOW;
          level_d = TLIC_IN_LOW;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      level_q      <= TLIC_RUN;
      low_nested_q <= 1'b0;
      cyc_q        <= 2'h0;
      wait_q       <= 2'h0;
      pend_q       <= 1'b0;
      pend_high_q  <= 1'b0;
      take_q       <= 1'b0;
      vec_q        <= 21'h000000;
      ret_q        <= 21'h000000;
    end else begin
      level_q      <= level_d;
      low_nested_q <= low_nested_d;
      cyc_q        <= cyc_d;
      wait_q       <= wait_d;
      pend_q       <= pend_d;
      pend_high_q  <= pend_high_d;
      take_q       <= take_d;
      vec_q        <= vec_d;
      ret_q        <= ret_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Zero outside the read slot so a stray sample shows nothing stale
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TLIC_OFF_CTRL_MAIN:  rdata_d = ctrl_q;
        `TLIC_OFF_RESET_CTRL: rdata_d = reset_control_reg_q;
        `TLIC_OFF_EDGE_PRIO:  rdata_d = edge_prio_q;
        `TLIC_OFF_PERI_FLAG:  rdata_d[NUM_PERI-1:0] = pflag_q;
        `TLIC_OFF_PERI_EN:    rdata_d[NUM_PERI-1:0] = pen_q;
        `TLIC_OFF_PERI_PRIO:  rdata_d[NUM_PERI-1:0] = pprio_q;
        `TLIC_OFF_STATUS:     rdata_d = {6'h00, level_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Push and vector load share one pulse so the core sees them together
  assign irq_take        = take_q;
  assign stack_push      = take_q;
  assign irq_vector      = vec_q;
  assign stack_push_addr = ret_q;
  assign reg_rdata       = rdata_q;
  assign active_level    = {6'h00, level_q};

endmodule : tlic_core

/* File: sim/tlic_props.sv */
// Port checker for the interrupt controller
`timescale 1ns/1ns
module tlic_props (
  // Clock, reset
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  // Register port
  input wire logic [3:0]           reg_addr,
  input wire tlic_pkg::tlic_byte_t reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire tlic_pkg::tlic_byte_t reg_rdata,
  // Core side
  input wire logic                 irq_take,
  input wire tlic_pkg::tlic_addr_t irq_vector,
  input wire logic                 stack_push,
  input wire tlic_pkg::tlic_byte_t active_level
);
  import tlic_pkg::*;
  logic prio_q;
  logic prio_d;
  // Mirror of the mode bit, since the checker sees no registers
  always_comb begin
    prio_d = prio_q;
    if (reg_wr && reg_addr == 4'h1) prio_d = reg_wdata[7];
  end
  always_ff @(posedge sys_clk) prio_q <= rst_b ? prio_d : 1'b0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_push_with_take: assert property (irq_take == stack_push)
    else $error("push and take differ");
  a_take_one_pulse: assert property (irq_take |=> !irq_take)
    else $error("take longer than one cycle");
  a_vector_legal: assert property (irq_take |-> irq_vector inside {21'h8, 21'h18})
    else $error("vector not legal");
  a_compat_vector: assert property (irq_take && !prio_q |-> irq_vector == 21'h8)
    else $error("compatibility vector wrong");
  a_vector_holds: assert property ($changed(irq_vector) |-> irq_take)
    else $error("vector moved without take");
  a_low_level: assert property (irq_take && prio_q && irq_vector == 21'h18
    |-> ##[0:1] active_level == 8'h01) else $error("low level not entered");
  a_high_level: assert property (irq_take && prio_q && irq_vector == 21'h8
    |-> ##[0:1] active_level == 8'h02) else $error("high level not entered");
  a_low_held_off: assert property (active_level == 8'h02 && prio_q
    |-> !(irq_take && irq_vector == 21'h18)) else $error("low preempted high");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  c_low: cover property (irq_take && irq_vector == 21'h18);
  c_high: cover property (irq_take && irq_vector == 21'h8);
  c_preempt: cover property (irq_take && $past(active_level) == 8'h01);
endmodule : tlic_props

bind tlic_core tlic_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_take(irq_take), .irq_vector(irq_vector), .stack_push(stack_push),
  .active_level(active_level));

/* File: sim/tlic_core_model.sv */
// Processor core stand-in: program counter, return stack, return pulses
`timescale 1ns/1ns
module tlic_core_model (
  // Clock, reset
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  // Vector handshake
  input wire logic                 stack_push,
  input wire tlic_pkg::tlic_addr_t stack_push_addr,
  output tlic_pkg::tlic_addr_t     core_pc,
  output logic                     return_from_irq_instr
);
  import tlic_pkg::*;
  tlic_addr_t stack_q[$];
  initial begin
    core_pc = 21'h000100;
    return_from_irq_instr = 1'b0;
  end
  // Moving count, so a stale return address would show
  always @(posedge sys_clk) begin
    core_pc <= rst_b ? core_pc + 21'h000002 : 21'h000100;
    if (stack_push) stack_q.push_back(stack_push_addr);
  end
  task automatic do_return();
    @(posedge sys_clk);
    if (stack_q.size() > 0) void'(stack_q.pop_back());
    return_from_irq_instr <= 1'b1;
    @(posedge sys_clk);
    return_from_irq_instr <= 1'b0;
  endtask : do_return
endmodule : tlic_core_model

/* File: sim/tb_tlic_core.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
module tb_tlic_core;
  import tlic_pkg::*;
  logic       sys_clk, rst_b, reg_wr, reg_rd, ext_pin0, timer0_overflow, rd_seen;
  logic       return_from_irq_instr, irq_take, stack_push;
  logic [3:0] reg_addr, upper_portb_pins;
  tlic_byte_t reg_wdata, reg_rdata, active_level, peri_event, pv;
  tlic_addr_t core_pc, irq_vector, stack_push_addr, pc_seen;
  int         n_errors, n_compared, seed, lat;
  tlic_byte_t exp_rd[$];
  tlic_addr_t exp_vec[$];
  tlic_byte_t rst_v[8] = '{8'h00, 8'h00, 8'h45, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};

  tlic_core #(.NUM_PERI(8)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin0(ext_pin0), .upper_portb_pins(upper_portb_pins),
    .timer0_overflow(timer0_overflow), .peri_event(peri_event), .core_pc(core_pc),
    .return_from_irq_instr(return_from_irq_instr), .irq_take(irq_take),
    .irq_vector(irq_vector), .stack_push(stack_push), .stack_push_addr(stack_push_addr),
    .active_level(active_level));
  tlic_core_model u_core (.sys_clk(sys_clk), .rst_b(rst_b), .stack_push(stack_push),
    .stack_push_addr(stack_push_addr), .core_pc(core_pc),
    .return_from_irq_instr(return_from_irq_instr));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic cmp8(input tlic_byte_t got, input tlic_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp21(input tlic_addr_t got, input tlic_addr_t exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t vector %h expected %h", $time, got, exp);
    end
  endtask : cmp21

  task automatic wr(input logic [3:0] a, input tlic_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input tlic_byte_t e);
    @(posedge sys_clk);
    exp_rd.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic pulse(input logic t0, input tlic_byte_t p);
    @(posedge sys_clk);
    timer0_overflow <= t0;
    peri_event <= p;
    @(posedge sys_clk);
    timer0_overflow <= 1'b0;
    peri_event <= 8'h00;
  endtask : pulse

  // Bounded wait; an unexpected take is caught by the monitor's empty queue
  task automatic wait_take(input tlic_addr_t v);
    exp_vec.push_back(v);
    lat = 0;
    do begin
      @(posedge sys_clk);
      lat++;
      if (lat > 40) begin
        n_errors++;
        $display("[ERR] %0t no vector taken", $time);
        test_done();
      end
    end while (irq_take !== 1'b1);
  endtask : wait_take

  always @(posedge sys_clk) begin
    if (rd_seen) cmp8(reg_rdata, exp_rd.pop_front());
    if (irq_take) cmp21(irq_vector, exp_vec.pop_front());
    // Return address is the count the core showed at acceptance
    if (irq_take) cmp21(stack_push_addr, pc_seen);
    rd_seen <= reg_rd;
    pc_seen <= core_pc;
  end

  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, ext_pin0, rd_seen} = '0;
    {upper_portb_pins, timer0_overflow, peri_event, n_errors, n_compared} = '0;
    seed = 32'h83c8066c;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rst_v[i]) rd(4'(i), rst_v[i]);
    $display("Test reset values done");
    pulse(1'b1, 8'h00);
    ext_pin0 <= 1'b1;
    upper_portb_pins <= 4'h5;
    repeat (8) @(posedge sys_clk);
    rd(4'h0, 8'h07);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    repeat (4) begin
      pv = 8'($random(seed));
      pulse(1'b0, pv);
      rd(4'h3, pv);
      wr(4'h3, 8'h00);
    end
    $display("Test flags done");
    wr(4'h0, 8'hA0);
    pulse(1'b1, 8'h00);
    wait_take(21'h000008);
    rd(4'h0, 8'h24);
    wr(4'h0, 8'h20);
    u_core.do_return();
    rd(4'h0, 8'hA0);
    wr(4'h4, 8'h01);
    pulse(1'b0, 8'h01);
    repeat (20) @(posedge sys_clk);
    wr(4'h0, 8'hC0);
    wait_take(21'h000008);
    wr(4'h3, 8'h00);
    u_core.do_return();
    wr(4'h4, 8'h00);
    $display("Test compatibility done");
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h41);
    wr(4'h0, 8'h68);
    pulse(1'b1, 8'h00);
    wait_take(21'h000018);
    rd(4'h6, 8'h01);
    rd(4'h0, 8'h2C);
    wr(4'h0, 8'hA8);
    upper_portb_pins <= 4'hF;
    wait_take(21'h000008);
    // Three to four instruction cycles, plus one edge of sampling lag
    cmp8(8'(lat >= 10 && lat <= 13), 8'h01);
    rd(4'h6, 8'h02);
    rd(4'h0, 8'h29);
    wr(4'h0, 8'h28);
    u_core.do_return();
    rd(4'h6, 8'h01);
    u_core.do_return();
    rd(4'h0, 8'hE8);
    repeat (3) @(posedge sys_clk);
    $display("Test priority done");
    test_done();
  end
endmodule : tb_tlic_core
